/* File: actrim_cfg.svh */
`ifndef ACTRIM_CFG_SVH
`define ACTRIM_CFG_SVH
// register addresses
`define ACTRIM_ADDR_I_OFFSET 4'h2
`define ACTRIM_ADDR_I_GAIN 4'h3
`define ACTRIM_ADDR_EXT_CFG 4'h9
`define ACTRIM_ADDR_Q_OFFSET 4'ha
`define ACTRIM_ADDR_Q_GAIN 4'hb
`define ACTRIM_ADDR_FINE 4'he
`define ACTRIM_ADDR_COARSE 4'hf
// reset values
`define ACTRIM_RST_OFFSET 16'h007f
`define ACTRIM_RST_GAIN 16'h807f
`define ACTRIM_RST_EXT_CFG 16'h03ff
`define ACTRIM_RST_FINE 16'h00ff
`define ACTRIM_RST_COARSE 16'h007f
// frame layout
`define ACTRIM_HEADER 12'h001
`define ACTRIM_FRAME_BITS 6'd32
// field positions
`define ACTRIM_OFS_MAG_HI 15
`define ACTRIM_OFS_MAG_LO 8
`define ACTRIM_OFS_SIGN 7
`define ACTRIM_GAIN_HI 15
`define ACTRIM_GAIN_LO 7
`define ACTRIM_EXT_PATTERN 15
`define ACTRIM_EXT_TRIM_SKIP 14
`define ACTRIM_EXT_INTERLEAVE 13
`define ACTRIM_EXT_INPUT 12
`define ACTRIM_EXT_SLOW_TUNE 10
`define ACTRIM_FINE_HI 15
`define ACTRIM_FINE_LO 8
`define ACTRIM_CRS_INVERT 15
`define ACTRIM_CRS_HI 14
`define ACTRIM_CRS_LO 10
`define ACTRIM_MID_HI 9
`define ACTRIM_MID_LO 7
`endif

/* File: actrim_pkg.sv */
package actrim_pkg;
  // per-channel analog trim
  typedef struct packed {
    logic [7:0] offset_mag;
    logic offset_negative;
    logic [8:0] gain;
  } actrim_chan_t;
  // extended mode bits
  typedef struct packed {
    logic pattern_out_enable;
    logic termination_trim_skip;
    logic interleave_enable_field;
    logic interleave_input_choice;
    logic interleave_slow_clock_tune;
  } actrim_mode_t;
  // sample clock delay settings
  typedef struct packed {
    logic sample_clock_invert;
    logic [4:0] coarse_delay;
    logic [2:0] mid_step_delay;
    logic [7:0] fine_delay;
  } actrim_clk_t;
  typedef enum logic [1:0] {
    ACTRIM_IDLE,
    ACTRIM_SHIFT,
    ACTRIM_COMMIT
  } actrim_state_t;
endpackage

/* File: actrim_shift.sv */
`timescale 1ns/1ns
`include "actrim_cfg.svh"
// frame deserialiser: reports a complete 32-bit frame with a good header
module actrim_shift
  import actrim_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // serial port
  input wire logic serial_chip_select_n,
  input wire logic serial_shift_input,
  // decoded frame
  output logic frame_valid,
  output logic [3:0] frame_addr,
  output logic [15:0] frame_data
);
  typedef struct packed {
    logic [31:0] shreg;
    logic [5:0] count;
    logic valid;
  } actrim_shift_st_t;
  actrim_shift_st_t st;
  actrim_shift_st_t next_st;
  logic [31:0] shifted;

  // msb first; counter restarts so frames may follow from the 33rd edge
  always_comb begin
    next_st = st;
    shifted = {st.shreg[30:0], serial_shift_input};
    next_st.valid = 1'b0;
    if (serial_chip_select_n) begin
      next_st.count = 6'd0; // R21
    end else begin
      next_st.shreg = shifted; // R18
      if (st.count == `ACTRIM_FRAME_BITS - 6'd1) begin
        next_st.count = 6'd0; // R19
        next_st.valid = (shifted[31:20] == `ACTRIM_HEADER); // R21
      end else begin
        next_st.count = st.count + 6'd1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign frame_valid = st.valid;
  assign frame_addr = st.shreg[19:16];
  assign frame_data = st.shreg[15:0];
endmodule

/* File: actrim_gate.sv */
`timescale 1ns/1ns
// holds outputs at reset defaults unless extended control is active
module actrim_gate #(
  parameter int WIDTH = 16
) (
  // select and values
  input wire logic extended_mode,
  input wire logic [WIDTH-1:0] programmed,
  input wire logic [WIDTH-1:0] fallback,
  // result
  output logic [WIDTH-1:0] effective
);
  // pin-controlled mode ignores register contents
  assign effective = extended_mode ? programmed : fallback; // R20
endmodule

/* File: actrim_regs.sv */
`timescale 1ns/1ns
`include "actrim_cfg.svh"
////////////////////////////////////////////////////////////////////////////////
// Operation
// R1: offset bits 15:8 give linear offset magnitude, zero to about 45 mV.
// R2: offset bit 7 picks sign, one is negative; resets to zero.
// R3: host writes ones to offset bits 6:0; default zero magnitude positive.
// R4: gain bits 15:7 set full scale 560 to 840 mVpp, default 100000000b.
// R5: host keeps gain codes within the recommended band, ones in 6:0.
// R6: gain changes apply at once without any recalibration.
// R7: pattern bit replaces converter data and out-of-range with a generator.
// R8: trim skip bit skips termination trim, keeps data clock running.
// R9: interleave bit makes converters sample one input on alternate edges.
// R10: input choice bit routes I input when zero, Q input when one.
// R11: slow clock tune bit improves performance below 900 MHz clocks.
// R12: host writes zero to bit 11, ones to 9:0; mode bits reset cleared.
// R13: fine delay bits 15:8 give zero to about 50 ps of delay.
// R14: coarse register bit 15 inverts sample clock polarity; resets zero.
// R15: bits 14:10 add about 65 ps per step, default zero.
// R16: bits 9:7 add about 11 ps per step, combined up to 2.1 ns.
// R17: negative zero offset differs from positive zero by a tenth code.
// R18: frame is 32 bits msb first: header, 4-bit address, 16 data bits.
// R19: next frame may start on the 33rd clock without deselecting.
// R20: register contents have no effect in pin-controlled mode.
// R21: write only after full frame with valid header; drop partial frames.
module actrim_regs
  import actrim_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // serial port, sampled on rising clk
  input wire logic serial_chip_select_n,
  input wire logic serial_shift_input,
  // pin strap: high selects extended control
  input wire logic extended_mode,
  // trim outputs
  output actrim_chan_t i_trim,
  output actrim_chan_t q_trim,
  output actrim_mode_t mode,
  output actrim_clk_t clk_delay
);
  typedef struct packed {
    logic [15:0] i_channel_offset_trim;
    logic [15:0] i_channel_gain_trim;
    logic [15:0] extended_mode_config;
    logic [15:0] q_channel_offset_trim;
    logic [15:0] q_channel_gain_trim;
    logic [15:0] sample_clock_fine_delay;
    logic [15:0] sample_clock_coarse_delay;
    actrim_chan_t i_out;
    actrim_chan_t q_out;
    actrim_mode_t mode_out;
    actrim_clk_t clk_out;
  } actrim_regs_st_t;

  actrim_regs_st_t st;
  actrim_regs_st_t next_st;
  logic frame_valid;
  logic [3:0] frame_addr;
  logic [15:0] frame_data;
  logic [15:0] eff_i_ofs;
  logic [15:0] eff_i_gain;
  logic [15:0] eff_ext;
  logic [15:0] eff_q_ofs;
  logic [15:0] eff_q_gain;
  logic [15:0] eff_fine;
  logic [15:0] eff_coarse;

  // channel field split shared by both channels
  function automatic actrim_chan_t chan_decode(input logic [15:0] ofs, input logic [15:0] gain);
    actrim_chan_t c;
    c.offset_mag = ofs[`ACTRIM_OFS_MAG_HI:`ACTRIM_OFS_MAG_LO]; // R1
    c.offset_negative = ofs[`ACTRIM_OFS_SIGN]; // R2
    c.gain = gain[`ACTRIM_GAIN_HI:`ACTRIM_GAIN_LO]; // R4
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  actrim_shift u_shift (
    .clk(clk),
    .rstn(rstn),
    .serial_chip_select_n(serial_chip_select_n),
    .serial_shift_input(serial_shift_input),
    .frame_valid(frame_valid),
    .frame_addr(frame_addr),
    .frame_data(frame_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // pin mode: every field falls back to its reset default
  actrim_gate #(.WIDTH(16)) u_gate_i_ofs (
    .extended_mode(extended_mode),
    .programmed(st.i_channel_offset_trim),
    .fallback(`ACTRIM_RST_OFFSET),
    .effective(eff_i_ofs)
  );
  actrim_gate #(.WIDTH(16)) u_gate_i_gain (
    .extended_mode(extended_mode),
    .programmed(st.i_channel_gain_trim),
    .fallback(`ACTRIM_RST_GAIN),
    .effective(eff_i_gain)
  );
  actrim_gate #(.WIDTH(16)) u_gate_ext (
    .extended_mode(extended_mode),
    .programmed(st.extended_mode_config),
    .fallback(`ACTRIM_RST_EXT_CFG),
    .effective(eff_ext)
  );
  actrim_gate #(.WIDTH(16)) u_gate_q_ofs (
    .extended_mode(extended_mode),
    .programmed(st.q_channel_offset_trim),
    .fallback(`ACTRIM_RST_OFFSET),
    .effective(eff_q_ofs)
  );
  actrim_gate #(.WIDTH(16)) u_gate_q_gain (
    .extended_mode(extended_mode),
    .programmed(st.q_channel_gain_trim),
    .fallback(`ACTRIM_RST_GAIN),
    .effective(eff_q_gain)
  );
  actrim_gate #(.WIDTH(16)) u_gate_fine (
    .extended_mode(extended_mode),
    .programmed(st.sample_clock_fine_delay),
    .fallback(`ACTRIM_RST_FINE),
    .effective(eff_fine)
  );
  actrim_gate #(.WIDTH(16)) u_gate_coarse (
    .extended_mode(extended_mode),
    .programmed(st.sample_clock_coarse_delay),
    .fallback(`ACTRIM_RST_COARSE),
    .effective(eff_coarse)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // register write and output decode
  always_comb begin
    next_st = st;
    // whole 16-bit word stored; must-be bits kept as written by the host
    if (frame_valid) begin // R21
      case (frame_addr)
        `ACTRIM_ADDR_I_OFFSET: begin
          next_st.i_channel_offset_trim = frame_data; // R3
        end
        `ACTRIM_ADDR_I_GAIN: begin
          next_st.i_channel_gain_trim = frame_data; // R5
        end
        `ACTRIM_ADDR_EXT_CFG: begin
          next_st.extended_mode_config = frame_data; // R12
        end
        `ACTRIM_ADDR_Q_OFFSET: begin
          next_st.q_channel_offset_trim = frame_data;
        end
        `ACTRIM_ADDR_Q_GAIN: begin
          next_st.q_channel_gain_trim = frame_data;
        end
        `ACTRIM_ADDR_FINE: begin
          next_st.sample_clock_fine_delay = frame_data;
        end
        `ACTRIM_ADDR_COARSE: begin
          next_st.sample_clock_coarse_delay = frame_data;
        end
        default: begin
          // calibration, configuration and reserved addresses belong elsewhere
          next_st = st;
        end
      endcase
    end
    // gain goes straight to trim; no calibration handshake involved
    next_st.i_out = chan_decode(eff_i_ofs, eff_i_gain); // R6
    // sign passed apart from magnitude so minus zero stays distinct
    next_st.q_out = chan_decode(eff_q_ofs, eff_q_gain); // R17
    next_st.mode_out.pattern_out_enable = eff_ext[`ACTRIM_EXT_PATTERN]; // R7
    next_st.mode_out.termination_trim_skip = eff_ext[`ACTRIM_EXT_TRIM_SKIP]; // R8
    next_st.mode_out.interleave_enable_field = eff_ext[`ACTRIM_EXT_INTERLEAVE]; // R9
    next_st.mode_out.interleave_input_choice = eff_ext[`ACTRIM_EXT_INPUT]; // R10
    next_st.mode_out.interleave_slow_clock_tune = eff_ext[`ACTRIM_EXT_SLOW_TUNE]; // R11
    next_st.clk_out.fine_delay = eff_fine[`ACTRIM_FINE_HI:`ACTRIM_FINE_LO]; // R13
    next_st.clk_out.sample_clock_invert = eff_coarse[`ACTRIM_CRS_INVERT]; // R14
    next_st.clk_out.coarse_delay = eff_coarse[`ACTRIM_CRS_HI:`ACTRIM_CRS_LO]; // R15
    next_st.clk_out.mid_step_delay = eff_coarse[`ACTRIM_MID_HI:`ACTRIM_MID_LO]; // R16
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register; outputs reset to the decoded defaults
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st.i_channel_offset_trim <= `ACTRIM_RST_OFFSET;
      st.i_channel_gain_trim <= `ACTRIM_RST_GAIN;
      st.extended_mode_config <= `ACTRIM_RST_EXT_CFG;
      st.q_channel_offset_trim <= `ACTRIM_RST_OFFSET;
      st.q_channel_gain_trim <= `ACTRIM_RST_GAIN;
      st.sample_clock_fine_delay <= `ACTRIM_RST_FINE;
      st.sample_clock_coarse_delay <= `ACTRIM_RST_COARSE;
      st.i_out <= {8'h00, 1'b0, 9'h100};
      st.q_out <= {8'h00, 1'b0, 9'h100};
      st.mode_out <= '0;
      st.clk_out <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign i_trim = st.i_out;
  assign q_trim = st.q_out;
  assign mode = st.mode_out;
  assign clk_delay = st.clk_out;
endmodule

/* File: actrim_regs_sva.sv */
`timescale 1ns/1ns
module actrim_regs_chk
  import actrim_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // serial port and strap
  input wire logic serial_chip_select_n,
  input wire logic serial_shift_input,
  input wire logic extended_mode,
  // trim outputs
  input actrim_chan_t i_trim,
  input actrim_chan_t q_trim,
  input actrim_mode_t mode,
  input actrim_clk_t clk_delay
);
  localparam logic [57:0] DEF = {18'h00100, 18'h00100, 22'h0};
  logic [4:0] cnt;
  logic [31:0] sh;
  logic [19:0] wd;
  logic wr1, wr2, ext_q;
  wire [57:0] outs = {i_trim, q_trim, mode, clk_delay};
  wire wrote = wr2 && extended_mode && ext_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  //////////////////////////////////////////////////////////////////////
  // shadow deserialiser; count clears whenever select is high
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 5'h0;
      sh <= 32'h0;
      wd <= 20'h0;
      wr1 <= 1'b0;
      wr2 <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      cnt <= serial_chip_select_n ? 5'h0 : cnt + 5'h1;
      if (!serial_chip_select_n) sh <= {sh[30:0], serial_shift_input};
      if (!serial_chip_select_n && cnt == 5'h1f) wd <= {sh[18:0], serial_shift_input};
      wr1 <= !serial_chip_select_n && cnt == 5'h1f && sh[30:19] == 12'h001;
      wr2 <= wr1;
      ext_q <= extended_mode;
    end
  end
  //////////////////////////////////////////////////////////////////////
  reset_defaults_a: assert property ($rose(rstn) |-> outs == DEF)
    else $error("outputs not at defaults after reset");
  pin_mode_a: assert property (!extended_mode |=> outs == DEF)
    else $error("pin mode does not force defaults");
  offset_write_a: assert property (wrote && wd[18:16] == 3'h2 |=>
    (wd[19] ? q_trim[17:9] : i_trim[17:9]) == wd[15:7]) else $error("offset write lost");
  gain_write_a: assert property (wrote && wd[18:16] == 3'h3 |=>
    (wd[19] ? q_trim[8:0] : i_trim[8:0]) == wd[15:7]) else $error("gain write lost");
  mode_write_a: assert property (wrote && wd[19:16] == 4'h9 |=>
    mode == {wd[15:12], wd[10]}) else $error("mode write lost");
  fine_write_a: assert property (wrote && wd[19:16] == 4'he |=> clk_delay[7:0] == wd[15:8])
    else $error("fine delay write lost");
  coarse_write_a: assert property (wrote && wd[19:16] == 4'hf |=> clk_delay[16:8] == wd[15:7])
    else $error("coarse delay write lost");
  hold_value_a: assert property (!wr2 && extended_mode && ext_q |=> $stable(outs))
    else $error("outputs moved without a frame");
  // main scenarios
  cover property (wrote && wd[19:16] == 4'h9);
  cover property (!extended_mode ##1 extended_mode);
  cover property (wr1 ##32 wr1);
endmodule
bind actrim_regs actrim_regs_chk chk (.clk, .rstn, .serial_chip_select_n, .serial_shift_input,
  .extended_mode, .i_trim, .q_trim, .mode, .clk_delay);

/* File: actrim_host.sv */
`timescale 1ns/1ns
// host side of the serial port; frames are 32-bit counts, select may stay low between them
module actrim_host (
  // serial clock
  input wire logic clk,
  // serial port
  output logic serial_chip_select_n,
  output logic serial_shift_input
);
  initial begin
    serial_chip_select_n = 1'b1;
    serial_shift_input = 1'b0;
  end
  // shift nbits of w msb first; a short count makes a broken frame
  task automatic send(input logic [31:0] w, input int nbits, input bit rel);
    for (int i = 31; i > 31 - nbits; i--) begin
      @(posedge clk);
      serial_chip_select_n <= 1'b0;
      serial_shift_input <= w[i];
    end
    // without release the next call lands on bit 33
    if (rel) begin
      @(posedge clk);
      serial_chip_select_n <= 1'b1;
      serial_shift_input <= ~serial_shift_input;
    end
  endtask
endmodule

/* File: test_actrim_regs.sv */
`timescale 1ns/1ns
module test_actrim_regs
  import actrim_pkg::*;
;
  localparam logic [57:0] DEF = {18'h00100, 18'h00100, 22'h0};
  typedef struct {logic [3:0] addr; logic [15:0] data; logic [8:0] exp;} actrim_row_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic extended_mode = 1'b1;
  wire serial_chip_select_n;
  wire serial_shift_input;
  actrim_chan_t i_trim;
  actrim_chan_t q_trim;
  actrim_mode_t mode;
  actrim_clk_t clk_delay;
  logic [57:0] snap;
  int errors = 0;
  int n_compared = 0;
  wire [57:0] outs = {i_trim, q_trim, mode, clk_delay};
  // must-be bits written as required: ones low, zero at bit 11
  actrim_row_t rows[13] = '{'{4'h2, 16'h5aff, 9'h0b5}, '{4'h3, 16'he07f, 9'h1c0},
    '{4'ha, 16'hff7f, 9'h1fe}, '{4'hb, 16'h607f, 9'h0c0}, '{4'h9, 16'h83ff, 9'h010},
    '{4'h9, 16'h43ff, 9'h008}, '{4'h9, 16'h23ff, 9'h004}, '{4'h9, 16'h13ff, 9'h002},
    '{4'h9, 16'h07ff, 9'h001}, '{4'he, 16'hc3ff, 9'h0c3}, '{4'hf, 16'hfcff, 9'h1f9},
    '{4'hf, 16'h2b7f, 9'h056}, '{4'h2, 16'h00ff, 9'h001}};
  always #4 clk = ~clk;
  actrim_host host (.clk, .serial_chip_select_n, .serial_shift_input);
  actrim_regs dut (.clk, .rstn, .serial_chip_select_n, .serial_shift_input, .extended_mode,
    .i_trim, .q_trim, .mode, .clk_delay);
  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [57:0] seen, input logic [57:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // the output field a register drives
  function automatic logic [8:0] field(input logic [3:0] a);
    case (a)
      4'h2: return i_trim[17:9];
      4'h3: return i_trim[8:0];
      4'ha: return q_trim[17:9];
      4'hb: return q_trim[8:0];
      4'h9: return {4'h0, mode};
      4'he: return {1'b0, clk_delay[7:0]};
      default: return clk_delay[16:8];
    endcase
  endfunction
  // outputs settle two edges after the last bit
  task automatic put(input logic [3:0] a, input logic [15:0] d);
    host.send({12'h001, a, d}, 32, 1'b1);
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    finish_test();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    #1;
    check(outs, DEF);
    foreach (rows[k]) begin
      put(rows[k].addr, rows[k].data);
      check(58'(field(rows[k].addr)), 58'(rows[k].exp));
    end
    // bad header, reserved places and a cut frame leave all unchanged
    snap = outs;
    host.send({12'h002, 4'h2, 16'h55ff}, 32, 1'b1);
    host.send({12'h001, 4'h2, 16'h77ff}, 20, 1'b1);
    put(4'h4, 16'h0000);
    put(4'hd, 16'hffff);
    check(outs, snap);
    // a good frame right after the refused ones still lands
    put(4'h2, 16'h12ff);
    check(outs, {9'h025, snap[48:0]});
    // back to back frames without releasing select
    host.send({12'h001, 4'he, 16'h11ff}, 32, 1'b0);
    put(4'hb, 16'h807f);
    check(58'(field(4'he)), 58'h11);
    check(58'(field(4'hb)), 58'h100);
    // pin mode hides, but keeps, the stored values
    snap = outs;
    @(posedge clk);
    extended_mode <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(outs, DEF);
    @(posedge clk);
    extended_mode <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(outs, snap);
    @(posedge clk);
    rstn <= 1'b0;
    #1;
    check(outs, DEF);
    @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(outs, DEF);
    // first frame after a mid-run reset; other stored words stay at defaults
    put(4'h9, 16'h83ff);
    check(outs, {DEF[57:22], 5'h10, 17'h0});
    finish_test();
  end
endmodule
